// [common/pcp_pkg.sv]
// constants for the port pin control block
package pcp_pkg;
  // register offsets
  localparam logic [2:0] PCP_REG_PA_DATA = 3'h0;
  localparam logic [2:0] PCP_REG_PA_DIR  = 3'h1;
  localparam logic [2:0] PCP_REG_PB_DATA = 3'h2;
  localparam logic [2:0] PCP_REG_PB_DIR  = 3'h3;
  localparam logic [2:0] PCP_REG_BIT_OP  = 3'h4;
  localparam logic [2:0] PCP_REG_IRQ_ST  = 3'h5;
  localparam logic [2:0] PCP_REG_IRQ_MSK = 3'h6;
  localparam logic [2:0] PCP_REG_OPTION  = 3'h7;
  // bit operation word fields
  localparam int PCP_BOP_PORT_POS = 0;
  localparam int PCP_BOP_IDX_LSB  = 1;
  localparam int PCP_BOP_VAL_POS  = 4;
  // option byte field: 1 selects the external reset role
  localparam int PCP_OPT_RST_ROLE_POS = 0;
  // pin positions
  localparam int PCP_IRQ_SHARED_PIN_A_BIT = 1;
  localparam int PCP_OSC_SHARED_PIN_A_BIT = 2;
  localparam int PCP_OSC_SHARED_PIN_B_BIT = 3;
  localparam int PCP_IRQ_SHARED_PIN_B_BIT = 2;
  localparam int PCP_RESET_SHARED_PIN_BIT = 4;
  localparam logic [7:0] PCP_PB_FORCE_IN = 8'h10;
  // reset values
  localparam logic [7:0] PCP_DIR_RST   = 8'hff;
  localparam logic [7:0] PCP_LATCH_RST = 8'h00;
  localparam logic [1:0] PCP_MSK_RST   = 2'h3;
  // cycles the option byte read takes after reset release
  localparam logic [2:0] PCP_OPT_READ_CYCLES = 3'h4;
  typedef enum logic {PCP_RC_READ, PCP_RC_RUN} pcp_rc_state_t;
endpackage

// [rtl/pcp_port8.sv]
// one 8-bit port: output latch, direction, single-bit read-modify-write
`timescale 1ns/1ps
module pcp_port8 import pcp_pkg::*; #(
  parameter logic [7:0] FORCE_IN = 8'h00
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic       coreHold,
  // software side
  input  wire logic       latchWr,
  input  wire logic       dirWr,
  input  wire logic       bitOp,
  input  wire logic [2:0] bitIdx,
  input  wire logic       bitVal,
  input  wire logic [7:0] wrData,
  output logic      [7:0] readVal,
  output logic      [7:0] dir,
  // pin side
  input  wire logic [7:0] pinIn,
  output logic      [7:0] pinOut,
  output logic      [7:0] pinOe
);
  logic [7:0] next_latch;

  // inputs read the pin, outputs read the latch
  assign readVal = (dir & pinIn) | (~dir & pinOut);

  always_comb
  begin
    next_latch = pinOut;
    if (latchWr)
      next_latch = wrData;
    else if (bitOp)
    begin
      // whole port is read back, so input-mode latches pick up pin levels
      next_latch = readVal;
      next_latch[bitIdx] = bitVal;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      pinOut <= PCP_LATCH_RST;
    else if (coreHold)
      pinOut <= PCP_LATCH_RST;
    else
      pinOut <= next_latch;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dir   <= PCP_DIR_RST;
      pinOe <= 8'h00;
    end
    else if (coreHold)
    begin
      dir   <= PCP_DIR_RST;
      pinOe <= 8'h00;
    end
    else if (dirWr)
    begin
      dir   <= wrData | FORCE_IN;
      pinOe <= ~(wrData | FORCE_IN);
    end
  end
endmodule

// [rtl/pcp_reset_ctl.sv]
// option byte load and role of the reset-shared pin
`timescale 1ns/1ps
module pcp_reset_ctl import pcp_pkg::*; (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  // pin and stored option
  input  wire logic       resetPinIn,
  input  wire logic [7:0] optByte,
  // status
  output logic            coreHold,
  output logic [7:0]      optShadow
);
  pcp_rc_state_t state;
  logic [2:0]    readCnt;
  logic          roleReset;

  assign coreHold  = (state == PCP_RC_READ);
  assign roleReset = optShadow[PCP_OPT_RST_ROLE_POS];

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state     <= PCP_RC_READ;
      readCnt   <= 3'h0;
      optShadow <= 8'h00;
    end
    else
    begin
      unique case (state)
        PCP_RC_READ:
        begin
          // a low pin before the read completes keeps the chip in reset
          if (!resetPinIn)
            readCnt <= 3'h0;
          else if (readCnt == PCP_OPT_READ_CYCLES - 3'h1)
          begin
            optShadow <= optByte;
            state     <= PCP_RC_RUN;
          end
          else
            readCnt <= readCnt + 3'h1;
        end
        PCP_RC_RUN:
        begin
          // port role ignores the pin for reset purposes
          if (roleReset && !resetPinIn)
          begin
            state   <= PCP_RC_READ;
            readCnt <= 3'h0;
          end
        end
      endcase
    end
  end
endmodule

// [rtl/pcp_port_pin_control.sv]
// port pin control: two ports, shared pins, interrupts and register access
//
// What this block does
// - While reset is held, both oscillator-shared pins are pulled low.
// - The stored option byte makes the reset-shared pin either reset input or input port.
// - The option byte is read after reset release, and a low pin before then holds reset.
// - A level change on an interrupt-shared pin in output mode sets its request flag.
// - A single-bit port operation rewrites the whole 8-bit port from its read value.
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
module pcp_port_pin_control import pcp_pkg::*; (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  // register port
  input  wire logic [2:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdata,
  // stored option byte
  input  wire logic [7:0] optByte,
  // port a pins
  input  wire logic [7:0] paIn,
  output logic      [7:0] paOut,
  output logic      [7:0] paOe,
  // port b pins
  input  wire logic [7:0] pbIn,
  output logic      [7:0] pbOut,
  output logic      [7:0] pbOe,
  // pull-downs on the oscillator-shared pins
  output logic      [1:0] oscPullDn,
  // system state
  output logic            coreResetHold,
  output logic            irq
);
  ////////////////////////////////////////////////////////////////////////
  logic       coreHold;
  logic [7:0] optShadow;
  logic [7:0] paRead;
  logic [7:0] pbRead;
  logic [7:0] paDir;
  logic [7:0] pbDir;
  logic       wrOk;
  logic       bopWr;
  logic       bopPortB;
  logic [2:0] bopIdx;
  logic       bopVal;
  logic [1:0] irqLvl;
  logic [1:0] irqPrev;
  logic [1:0] irqEvt;
  logic [1:0] irqSt;
  logic [1:0] irqMsk;
  logic [1:0] next_irqSt;
  logic [7:0] next_rdata;

  pcp_reset_ctl u_rst (
    .sys_clk    (sys_clk),
    .rst_b      (rst_b),
    .resetPinIn (pbIn[PCP_RESET_SHARED_PIN_BIT]),
    .optByte    (optByte),
    .coreHold   (coreHold),
    .optShadow  (optShadow)
  );

  ////////////////////////////////////////////////////////////////////////
  // register writes are dropped while reset is held
  assign wrOk     = regWr && !coreHold;
  assign bopWr    = wrOk && (regAddr == PCP_REG_BIT_OP);
  assign bopPortB = regWdata[PCP_BOP_PORT_POS];
  assign bopIdx   = regWdata[PCP_BOP_IDX_LSB +: 3];
  assign bopVal   = regWdata[PCP_BOP_VAL_POS];

  pcp_port8 #(
    .FORCE_IN (8'h00)
  ) u_pa (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .coreHold (coreHold),
    .latchWr  (wrOk && (regAddr == PCP_REG_PA_DATA)),
    .dirWr    (wrOk && (regAddr == PCP_REG_PA_DIR)),
    .bitOp    (bopWr && !bopPortB),
    .bitIdx   (bopIdx),
    .bitVal   (bopVal),
    .wrData   (regWdata),
    .readVal  (paRead),
    .dir      (paDir),
    .pinIn    (paIn),
    .pinOut   (paOut),
    .pinOe    (paOe)
  );

  // reset-shared pin is input only in both roles
  pcp_port8 #(
    .FORCE_IN (PCP_PB_FORCE_IN)
  ) u_pb (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .coreHold (coreHold),
    .latchWr  (wrOk && (regAddr == PCP_REG_PB_DATA)),
    .dirWr    (wrOk && (regAddr == PCP_REG_PB_DIR)),
    .bitOp    (bopWr && bopPortB),
    .bitIdx   (bopIdx),
    .bitVal   (bopVal),
    .wrData   (regWdata),
    .readVal  (pbRead),
    .dir      (pbDir),
    .pinIn    (pbIn),
    .pinOut   (pbOut),
    .pinOe    (pbOe)
  );

  ////////////////////////////////////////////////////////////////////////
  // reset state outputs
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      oscPullDn     <= 2'h3;
      coreResetHold <= 1'b1;
    end
    else
    begin
      oscPullDn     <= {2{coreHold}};
      coreResetHold <= coreHold;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // external interrupts: any change of the pin level, driven or sampled
  assign irqLvl = {pbRead[PCP_IRQ_SHARED_PIN_B_BIT], paRead[PCP_IRQ_SHARED_PIN_A_BIT]};
  assign irqEvt = irqLvl ^ irqPrev;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      irqPrev <= 2'h0;
    else
      irqPrev <= irqLvl;
  end

  always_comb
  begin
    next_irqSt = irqSt;
    if (wrOk && (regAddr == PCP_REG_IRQ_ST))
      next_irqSt = irqSt & ~regWdata[1:0];
    // a new event wins over a clear in the same cycle
    next_irqSt = next_irqSt | irqEvt;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      irqSt <= 2'h0;
    else if (coreHold)
      irqSt <= 2'h0;
    else
      irqSt <= next_irqSt;
  end

  // mask bit 1 blocks the request, so a driven pin stays quiet
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      irqMsk <= PCP_MSK_RST;
    else if (coreHold)
      irqMsk <= PCP_MSK_RST;
    else if (wrOk && (regAddr == PCP_REG_IRQ_MSK))
      irqMsk <= regWdata[1:0];
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      irq <= 1'b0;
    else if (coreHold)
      irq <= 1'b0;
    else
      irq <= |(next_irqSt & ~irqMsk);
  end

  ////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the strobe
  always_comb
  begin
    next_rdata = 8'h00;
    unique case (regAddr)
      PCP_REG_PA_DATA: next_rdata = paRead;
      PCP_REG_PA_DIR:  next_rdata = paDir;
      PCP_REG_PB_DATA: next_rdata = pbRead;
      PCP_REG_PB_DIR:  next_rdata = pbDir;
      PCP_REG_BIT_OP:  next_rdata = 8'h00;
      PCP_REG_IRQ_ST:  next_rdata = {6'h00, irqSt};
      PCP_REG_IRQ_MSK: next_rdata = {6'h00, irqMsk};
      PCP_REG_OPTION:  next_rdata = optShadow;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      regRdata <= 8'h00;
    else if (regRd)
      regRdata <= next_rdata;
    else
      regRdata <= 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  logic [7:0] expA;
  always_comb
  begin
    expA = paRead;
    expA[bopIdx] = bopVal;
  end

  a_osc_pull_on: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    coreHold |=> (oscPullDn == 2'h3) && (paOe == 8'h00))
    else $error("oscillator pins not pulled down in reset");

  a_osc_pull_off: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    !coreHold |=> oscPullDn == 2'h0)
    else $error("pull-down left on outside reset");

  a_port_role_free: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (!coreHold && !optShadow[PCP_OPT_RST_ROLE_POS]) |=> !coreHold)
    else $error("port role pin caused a reset");

  a_reset_role_hit: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (!coreHold && optShadow[PCP_OPT_RST_ROLE_POS] && !pbIn[PCP_RESET_SHARED_PIN_BIT])
      |=> coreHold ##1 coreResetHold)
    else $error("reset role pin low did not reset");

  a_low_pin_hold: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (coreHold && !pbIn[PCP_RESET_SHARED_PIN_BIT]) |=> coreHold [*4])
    else $error("reset released too early after low pin");

  a_irq_out_edge: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (!coreHold && !paDir[PCP_IRQ_SHARED_PIN_A_BIT] && $changed(paOut[PCP_IRQ_SHARED_PIN_A_BIT]))
      |=> irqSt[0])
    else $error("output level change did not set request");

  a_bit_op_rmw: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (bopWr && !bopPortB) |=> paOut == $past(expA))
    else $error("bit operation did not rewrite whole port");

  a_dir_drive: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (wrOk && (regAddr == PCP_REG_PA_DIR)) |=> (paOe == ~$past(regWdata)))
    else $error("direction write did not steer output enable");

  a_read_pin: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (regRd && (regAddr == PCP_REG_PA_DATA)) |=> regRdata == $past(paRead))
    else $error("port read returned wrong value");
endmodule

// [test/pcp_pin_board.sv]
// board model: drives the input pins and resolves the shared pin levels
`timescale 1ns/1ps
module pcp_pin_board import pcp_pkg::*; (
  // design pin outputs
  input  wire logic [7:0] paOut,
  input  wire logic [7:0] paOe,
  input  wire logic [7:0] pbOut,
  input  wire logic [7:0] pbOe,
  input  wire logic [1:0] oscPullDn,
  // board stimulus
  input  wire logic [7:0] extA,
  input  wire logic [7:0] extB,
  input  wire logic       rstPinLow,
  // levels seen by the design
  output logic      [7:0] paIn,
  output logic      [7:0] pbIn
);
  always_comb
  begin
    paIn = (paOe & paOut) | (~paOe & extA);
    pbIn = (pbOe & pbOut) | (~pbOe & extB);
    // oscillator pins float on the board, so the pull-downs set them
    if (oscPullDn[0] && !paOe[PCP_OSC_SHARED_PIN_A_BIT])
      paIn[PCP_OSC_SHARED_PIN_A_BIT] = 1'b0;
    if (oscPullDn[1] && !paOe[PCP_OSC_SHARED_PIN_B_BIT])
      paIn[PCP_OSC_SHARED_PIN_B_BIT] = 1'b0;
    // pull-up on the reset-shared pin, shorted low on demand
    pbIn[PCP_RESET_SHARED_PIN_BIT] = !rstPinLow;
  end
endmodule

// [test/pcp_port_pin_control_tb.sv]
// self-checking bench for the port pin control block
`timescale 1ns/1ps
module pcp_port_pin_control_tb import pcp_pkg::*; ;
  logic       sys_clk;
  logic       rst_b;
  logic [2:0] regAddr;
  logic [7:0] regWdata;
  logic       regWr;
  logic       regRd;
  logic [7:0] regRdata;
  logic [7:0] optByte;
  logic [7:0] paIn, paOut, paOe, pbIn, pbOut, pbOe, extA, extB;
  logic [1:0] oscPullDn;
  logic       coreResetHold, irq, rstPinLow;
  int         nMismatch, nChecks;

  pcp_port_pin_control dut (.sys_clk(sys_clk), .rst_b(rst_b), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .optByte(optByte), .paIn(paIn), .paOut(paOut), .paOe(paOe), .pbIn(pbIn),
    .pbOut(pbOut), .pbOe(pbOe), .oscPullDn(oscPullDn),
    .coreResetHold(coreResetHold), .irq(irq));
  pcp_pin_board board (.paOut(paOut), .paOe(paOe), .pbOut(pbOut), .pbOe(pbOe),
    .oscPullDn(oscPullDn), .extA(extA), .extB(extB), .rstPinLow(rstPinLow),
    .paIn(paIn), .pbIn(pbIn));

  ////////////////////////////////////////////////////////////////////////////
  task automatic finishTest;
    $display("checks %0d mismatches %0d", nChecks, nMismatch);
    if (nMismatch == 0 && nChecks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    nChecks++;
    if (seen !== exp)
    begin
      nMismatch++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1;
    chk(regRdata, exp);
  endtask

  task automatic waitRun;
    int i;
    i = 0;
    while (coreResetHold !== 1'b0 && i < 40)
    begin
      idle(1);
      i++;
    end
    chk({7'h0, coreResetHold}, 8'h00);
  endtask

  task automatic doReset(input logic [7:0] opt, input logic pinLow);
    rst_b     <= 1'b0;
    optByte   <= opt;
    rstPinLow <= pinLow;
    idle(10);
    chk({6'h0, oscPullDn}, 8'h03);
    chk({7'h0, coreResetHold}, 8'h01);
    rst_b <= 1'b1;
    idle(2);
    chk({7'h0, coreResetHold}, 8'h01);
    // oscillator pins read low through their pull-downs while held
    rd(PCP_REG_PA_DATA, extA & 8'hf3);
    if (pinLow)
    begin
      idle(20);
      chk({7'h0, coreResetHold}, 8'h01);
      rstPinLow <= 1'b0;
      idle(2);
      chk({7'h0, coreResetHold}, 8'h01);
    end
    waitRun;
    chk({6'h0, oscPullDn}, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    nMismatch++;
    finishTest;
  end

  initial
  begin
    rst_b = 1'b0;
    regAddr = 3'h0;
    regWdata = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    optByte = 8'h01;
    extA = 8'h00;
    extB = 8'h5a;
    rstPinLow = 1'b0;
    nMismatch = 0;
    nChecks = 0;
    doReset(8'h01, 1'b1);
    rd(PCP_REG_OPTION, 8'h01);
    // reset role: a low pin while running holds the chip again
    rstPinLow <= 1'b1;
    idle(3);
    chk({7'h0, coreResetHold}, 8'h01);
    rstPinLow <= 1'b0;
    waitRun;
    // direction, latch and mixed read
    extA <= 8'h36;
    wr(PCP_REG_PA_DIR, 8'h0f);
    wr(PCP_REG_PA_DATA, 8'ha5);
    idle(2);
    chk(paOe, 8'hf0);
    chk(paOut, 8'ha5);
    rd(PCP_REG_PA_DATA, 8'ha6);
    // single-bit ops rewrite the whole port from its read value
    wr(PCP_REG_BIT_OP, 8'h0e);
    idle(1);
    chk(paOut, 8'h26);
    wr(PCP_REG_PB_DIR, 8'hea);
    wr(PCP_REG_BIT_OP, 8'h11);
    idle(1);
    chk(pbOe, 8'h05);
    chk(pbOut, 8'h5b);
    // output-mode level changes on both interrupt-shared pins
    wr(PCP_REG_IRQ_ST, 8'h03);
    wr(PCP_REG_IRQ_MSK, 8'h00);
    wr(PCP_REG_PA_DIR, 8'h0d);
    idle(3);
    chk({7'h0, irq}, 8'h00);
    wr(PCP_REG_PA_DATA, 8'h24);
    wr(PCP_REG_PB_DATA, 8'h5f);
    idle(3);
    chk({7'h0, irq}, 8'h01);
    rd(PCP_REG_IRQ_ST, 8'h03);
    wr(PCP_REG_IRQ_ST, 8'h01);
    rd(PCP_REG_IRQ_ST, 8'h02);
    wr(PCP_REG_IRQ_MSK, 8'h02);
    idle(3);
    chk({7'h0, irq}, 8'h00);
    // masked first, so driving the pin raises no interrupt
    wr(PCP_REG_IRQ_ST, 8'h02);
    wr(PCP_REG_IRQ_MSK, 8'h03);
    wr(PCP_REG_PA_DATA, 8'h26);
    idle(3);
    chk({7'h0, irq}, 8'h00);
    rd(PCP_REG_IRQ_ST, 8'h01);
    // port role: the pin is plain input and cannot reset
    doReset(8'h00, 1'b0);
    rd(PCP_REG_OPTION, 8'h00);
    rstPinLow <= 1'b1;
    idle(6);
    chk({7'h0, coreResetHold}, 8'h00);
    rd(PCP_REG_PB_DATA, 8'h4a);
    finishTest;
  end
endmodule
